// ---- src/byte_ram.sv ----
// 256 x 8 single-port ram with registered read data
// assumes: synchronous write, read data valid one cycle after address
module byte_ram #(
    parameter int WORDS = 256
) (
    input wire logic i_clk, // system clock
    mem_port_if.mem port    // access port
);
    logic [7:0] mem_r [WORDS];
    logic [7:0] rdata_r;

    always_ff @(posedge i_clk)
    begin
        if (port.we)
        begin
            mem_r[port.addr] <= port.wdata;
        end
        rdata_r <= mem_r[port.addr];
    end

    assign port.rdata = rdata_r;
endmodule

// ---- src/mem_port_if.sv ----
// ram port bundle between decoder and its storage arrays
// assumes: same clock as the decoder
interface mem_port_if;
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport ctrl (output we, output addr, output wdata, input rdata);
    modport mem (input we, input addr, input wdata, output rdata);
endinterface

// ---- src/memdec_pkg.sv ----
// memory-space decode constants: program map, data map, stack, pointers
// assumes: single clock domain, byte-wide core data path
package memdec_pkg;
    localparam logic [15:0] PROG_SPACE_LAST = 16'hFFFF;
    localparam logic [15:0] FLASH_LAST_8K = 16'h1FFF;
    localparam logic [15:0] FLASH_LAST_4K = 16'h0FFF;
    localparam logic [15:0] FLASH_LAST_2K = 16'h07FF;
    localparam logic [7:0] UPPER_HALF_START = 8'h80;
    localparam logic [7:0] BIT_AREA_BASE = 8'h20;
    localparam logic [7:0] BIT_AREA_LAST = 8'h2F;
    localparam logic [7:0] BANK_AREA_LAST = 8'h1F;
    localparam logic [7:0] STACK_RESET = 8'h07;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam int BANK_SEL_LOW_POS = 3;
    localparam int BANK_SEL_HIGH_POS = 4;
    localparam int IRAM_WORDS = 256;
    localparam int EXTERNAL_DATA_RAM_WORDS = 256;

    typedef enum logic [1:0]
    {
        TGT_IRAM = 2'b00,
        TGT_SPECIAL = 2'b01
    } data_target_t;

    typedef enum logic [1:0]
    {
        IDLE_ST = 2'b00,
        PUSH_INC_ST = 2'b01
    } stack_state_t;
endpackage

// ---- src/memory_space_decoder.sv ----
// memory-space decoder: flash map, internal ram, banks, bits, stack, ext ram
// assumes: core drives one access per cycle; read data one cycle later
//
// Behaviour
// - 64 kB program space, only flash implemented
// - flash contiguous from zero, size per variant
// - top flash byte is lock; above reserved
// - code reads flash; ext writes redirect when configured
// - ext moves go to ext ram by default
// - 512 bytes ram: 256 internal, 256 external
// - lower 128 bytes direct and indirect
// - upper half: direct to special, indirect ram
// - 0x00-0x1F four banks, one active
// - only registers zero and one index
// - bit address is 8*(byte-0x20)+bit
// - bit or byte access from operand type
// - push writes sp+1 then increments sp
// - stack pointer resets to 0x07
// - stack anywhere in 256-byte ram
// - 256-byte ext ram via both forms
// - ext ram ignores address high byte
// - data pointer 16-bit, byte-writable halves
// - 8-bit form uses register zero/one
// - ext location zero may clear on reset
// - ext ram usable without setup
// - bank bits 00..11 select 0x00..0x18
module memory_space_decoder #(
    parameter logic [15:0] FLASH_LAST = memdec_pkg::FLASH_LAST_8K
) (
    input wire logic i_clk,             // system clock
    input wire logic i_rst,             // async reset, high
    input wire logic [15:0] i_code_addr, // code_read_move address
    output logic o_code_in_flash,       // address maps onto flash
    output logic o_code_is_lock,        // address is lock byte
    output logic [15:0] o_flash_addr,   // flash cell address
    input wire logic i_data_req,        // internal data access
    input wire logic i_data_we,         // write strobe
    input wire logic i_data_indirect,   // indirect addressing
    input wire logic i_data_bit,        // bit operand
    input wire logic [7:0] i_data_addr, // direct/bit address
    input wire logic i_ptr_sel,         // index register one
    input wire logic [7:0] i_data_wdata, // write data
    input wire logic i_bit_wdata,       // bit write value
    output logic [7:0] o_data_rdata,    // byte read data
    output logic o_bit_rdata,           // bit read data
    output logic o_special_req,         // direct upper-half access
    output logic [7:0] o_special_addr,  // special register address
    input wire logic [1:0] i_bank_sel,  // bank_select_high, bank_select_low
    input wire logic i_push,            // push request
    input wire logic [7:0] i_push_data, // value to push
    input wire logic i_pop,             // pop request
    input wire logic i_sp_we,           // stack_pointer write
    input wire logic [7:0] i_sp_wdata,  // stack_pointer value
    output logic [7:0] o_stack_pointer, // current stack_pointer
    input wire logic i_dph_we,          // data_pointer_high write
    input wire logic i_dpl_we,          // data_pointer_low write
    input wire logic [7:0] i_dp_wdata,  // data pointer byte
    output logic [15:0] o_data_pointer, // current data_pointer
    input wire logic i_ext_req,         // ext_data_move access
    input wire logic i_ext_we,          // ext write
    input wire logic i_ext_use_dp,      // 16-bit form
    input wire logic [7:0] i_ext_wdata, // ext write data
    input wire logic i_flash_redirect,  // ext writes to flash
    output logic [7:0] o_ext_rdata,     // ext read data
    output logic o_flash_wr_req,        // redirected flash write
    output logic [15:0] o_flash_wr_addr, // flash write address
    output logic [7:0] o_flash_wr_data  // flash write data
);
    // ********************************
    // program space map
    // ********************************
    always_comb
    begin
        o_code_in_flash = (i_code_addr <= FLASH_LAST);
        o_code_is_lock = (i_code_addr == FLASH_LAST);
        o_flash_addr = o_code_in_flash ? i_code_addr : 16'h0000;
    end

    // ********************************
    // pointers and bank state
    // ********************************
    logic [7:0] sp_r, sp_nxt;
    logic [15:0] dp_r, dp_nxt;
    memdec_pkg::stack_state_t st_r, st_nxt;

    function automatic logic [7:0] bank_reg(input logic [1:0] bank, input logic [2:0] idx);
        bank_reg = {3'h0, bank, idx};
    endfunction

    // replace one bit of a byte, for the bit write-back
    function automatic logic [7:0] bit_merge(input logic [7:0] old, input logic [2:0] pos,
        input logic val);
        bit_merge = old;
        bit_merge[pos] = val;
    endfunction

    // ********************************
    // internal ram decode
    // ********************************
    mem_port_if iram_p ();
    mem_port_if external_data_ram_p ();
    logic bit_wr_r, bit_wr_nxt;
    logic bit_wval_r, bit_wval_nxt;
    logic [7:0] bit_addr_r, bit_addr_nxt;
    logic [7:0] byte_addr;
    logic [2:0] bit_pos_r, bit_pos_nxt;
    logic bit_rd_r, bit_rd_nxt;
    logic direct_upper;
    logic [7:0] bit_byte;
    logic [7:0] idx_addr;

    // index registers live in ram but are not read from it; cache last written values
    logic [7:0] idx_r [4][2];
    logic [7:0] idx_nxt [4][2];

    always_comb
    begin
        idx_addr = idx_r[i_bank_sel][i_ptr_sel];
        bit_byte = memdec_pkg::BIT_AREA_BASE + {4'h0, i_data_addr[6:3]};
        direct_upper = i_data_req && !i_data_indirect && !i_data_bit
            && (i_data_addr >= memdec_pkg::UPPER_HALF_START);
        if (i_data_bit)
        begin
            byte_addr = bit_byte;
        end
        else if (i_data_indirect)
        begin
            byte_addr = idx_addr;
        end
        else
        begin
            byte_addr = i_data_addr;
        end
        o_special_req = direct_upper;
        o_special_addr = direct_upper ? i_data_addr : 8'h00;
    end

    always_comb
    begin
        iram_p.we = 1'b0;
        iram_p.addr = byte_addr;
        iram_p.wdata = i_data_wdata;
        sp_nxt = sp_r;
        st_nxt = st_r;
        bit_pos_nxt = bit_pos_r;
        bit_rd_nxt = bit_rd_r;
        bit_wr_nxt = 1'b0;
        bit_wval_nxt = bit_wval_r;
        bit_addr_nxt = bit_addr_r;
        idx_nxt = idx_r;
        unique case (st_r)
            memdec_pkg::IDLE_ST:
            begin
                // write-back cycle of a bit write: push, pop and internal ram data requests are dropped
                if (bit_wr_r)
                begin
                    iram_p.we = 1'b1;
                    iram_p.addr = bit_addr_r;
                    iram_p.wdata = bit_merge(iram_p.rdata, bit_pos_r, bit_wval_r);
                end
                else if (i_push)
                begin
                    iram_p.we = 1'b1;
                    iram_p.addr = sp_r + 8'h01;
                    iram_p.wdata = i_push_data;
                    st_nxt = memdec_pkg::PUSH_INC_ST;
                end
                else if (i_pop)
                begin
                    iram_p.addr = sp_r;
                    sp_nxt = sp_r - 8'h01;
                end
                else if (i_data_req && !direct_upper)
                begin
                    bit_pos_nxt = i_data_addr[2:0];
                    bit_rd_nxt = i_data_bit;
                    iram_p.we = i_data_we && !i_data_bit;
                    bit_wr_nxt = i_data_we && i_data_bit;
                    bit_addr_nxt = byte_addr;
                    bit_wval_nxt = i_bit_wdata;
                end
            end
            memdec_pkg::PUSH_INC_ST:
            begin
                sp_nxt = sp_r + 8'h01;
                st_nxt = memdec_pkg::IDLE_ST;
            end
        endcase
        if (i_sp_we)
        begin
            sp_nxt = i_sp_wdata;
        end
        // keep the index cache in step with writes to registers zero and one
        if (iram_p.we && iram_p.addr == bank_reg(iram_p.addr[4:3], {2'b00, iram_p.addr[0]}))
        begin
            idx_nxt[iram_p.addr[4:3]][iram_p.addr[0]] = iram_p.wdata;
        end
    end

    // ********************************
    // external ram and data pointer
    // ********************************
    logic [15:0] ext_full;
    logic fl_req_nxt, fl_req_r;
    logic [15:0] fl_addr_r, fl_addr_nxt;
    logic [7:0] fl_data_r, fl_data_nxt;

    always_comb
    begin
        dp_nxt = dp_r;
        if (i_dph_we)
        begin
            dp_nxt[15:8] = i_dp_wdata;
        end
        if (i_dpl_we)
        begin
            dp_nxt[7:0] = i_dp_wdata;
        end
    end

    always_comb
    begin
        ext_full = i_ext_use_dp ? dp_r : {8'h00, idx_addr};
        external_data_ram_p.addr = ext_full[7:0];
        external_data_ram_p.wdata = i_ext_wdata;
        external_data_ram_p.we = i_ext_req && i_ext_we && !i_flash_redirect;
        fl_req_nxt = i_ext_req && i_ext_we && i_flash_redirect;
        fl_addr_nxt = fl_req_nxt ? ext_full : fl_addr_r;
        fl_data_nxt = fl_req_nxt ? i_ext_wdata : fl_data_r;
    end

    // ********************************
    // register stages
    // ********************************
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            sp_r <= memdec_pkg::STACK_RESET;
            st_r <= memdec_pkg::IDLE_ST;
            bit_pos_r <= 3'h0;
            bit_rd_r <= 1'b0;
            bit_wr_r <= 1'b0;
            bit_wval_r <= 1'b0;
            bit_addr_r <= memdec_pkg::BYTE_RESET;
            idx_r <= '{default: memdec_pkg::BYTE_RESET};
        end
        else
        begin
            sp_r <= sp_nxt;
            st_r <= st_nxt;
            bit_pos_r <= bit_pos_nxt;
            bit_rd_r <= bit_rd_nxt;
            bit_wr_r <= bit_wr_nxt;
            bit_wval_r <= bit_wval_nxt;
            bit_addr_r <= bit_addr_nxt;
            idx_r <= idx_nxt;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            dp_r <= 16'h0000;
        end
        else
        begin
            dp_r <= dp_nxt;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            fl_req_r <= 1'b0;
            fl_addr_r <= 16'h0000;
            fl_data_r <= memdec_pkg::BYTE_RESET;
        end
        else
        begin
            fl_req_r <= fl_req_nxt;
            fl_addr_r <= fl_addr_nxt;
            fl_data_r <= fl_data_nxt;
        end
    end

    byte_ram #(.WORDS(memdec_pkg::IRAM_WORDS)) iram_u (.i_clk(i_clk), .port(iram_p));
    // ext ram is not cleared on reset, so location zero keeps its value
    byte_ram #(.WORDS(memdec_pkg::EXTERNAL_DATA_RAM_WORDS)) external_data_ram_u (.i_clk(i_clk), .port(external_data_ram_p));

    // ********************************
    // outputs
    // ********************************
    // bit read shows the addressed bit of the byte read one cycle back
    assign o_data_rdata = iram_p.rdata;
    assign o_bit_rdata = bit_rd_r ? iram_p.rdata[bit_pos_r] : 1'b0;
    assign o_stack_pointer = sp_r;
    assign o_data_pointer = dp_r;
    assign o_ext_rdata = external_data_ram_p.rdata;
    assign o_flash_wr_req = fl_req_r;
    assign o_flash_wr_addr = fl_addr_r;
    assign o_flash_wr_data = fl_data_r;
endmodule

// ---- tb/core_map_model.sv ----
// model: program-map decode expected by the core
// assumes: combinational, same flash map parameter as the decoder
module core_map_model #(
    parameter logic [15:0] FLASH_LAST = 16'h1FFF
) (
    input wire logic [15:0] i_addr, // code address
    output logic o_in_flash,        // maps onto flash
    output logic o_is_lock          // lock byte
);
    assign o_in_flash = (i_addr <= FLASH_LAST);
    assign o_is_lock = (i_addr == FLASH_LAST);
endmodule

// ---- tb/memory_space_decoder_checker.sv ----
// checker: port relations of the memory-space decoder
// assumes: bound into memory_space_decoder, single clock domain
module msd_checker #(
    parameter logic [15:0] FLASH_LAST = 16'h1FFF
) (
    input wire logic i_clk, // system clock
    input wire logic i_rst, // async reset, high
    input wire logic [15:0] i_code_addr, // code address
    input wire logic o_code_in_flash, // flash hit
    input wire logic o_code_is_lock, // lock byte hit
    input wire logic [15:0] o_flash_addr, // flash cell address
    input wire logic i_data_req, // data access
    input wire logic i_data_indirect, // indirect mode
    input wire logic i_data_bit, // bit operand
    input wire logic [7:0] i_data_addr, // data address
    input wire logic o_special_req, // special access
    input wire logic i_push, // push request
    input wire logic i_pop, // pop request
    input wire logic i_sp_we, // stack pointer write
    input wire logic [7:0] o_stack_pointer, // stack pointer
    input wire logic i_dph_we, // pointer high write
    input wire logic i_dpl_we, // pointer low write
    input wire logic [7:0] i_dp_wdata, // pointer byte
    input wire logic [15:0] o_data_pointer, // data pointer
    input wire logic i_ext_req, // ext access
    input wire logic i_ext_we, // ext write
    input wire logic i_flash_redirect, // flash redirect
    input wire logic o_flash_wr_req // flash write request
);
    // ****
    // assertions
    // ****
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sp_reset_a: assert property ($fell(i_rst) |-> o_stack_pointer == 8'h07)
        else $error("stack pointer wrong after reset");
    flash_map_a: assert property (o_code_in_flash == (i_code_addr <= FLASH_LAST))
        else $error("flash range decode wrong");
    lock_byte_a: assert property (o_code_is_lock == (i_code_addr == FLASH_LAST))
        else $error("lock byte decode wrong");
    reserved_code_a: assert property
        (o_flash_addr == ((i_code_addr <= FLASH_LAST) ? i_code_addr : 16'h0000))
        else $error("reserved code address decoded");
    special_dec_a: assert property (o_special_req == (i_data_req && !i_data_indirect
        && !i_data_bit && i_data_addr >= 8'h80)) else $error("special space decode wrong");
    push_inc_a: assert property (i_push && !i_sp_we |-> ##2
        o_stack_pointer == $past(o_stack_pointer, 2) + 8'h01) else $error("push increment");
    pop_dec_a: assert property (i_pop |=> o_stack_pointer == $past(o_stack_pointer) - 8'h01)
        else $error("pop decrement");
    dp_high_a: assert property (i_dph_we |=> o_data_pointer[15:8] == $past(i_dp_wdata))
        else $error("pointer high byte");
    dp_low_a: assert property (i_dpl_we |=> o_data_pointer[7:0] == $past(i_dp_wdata))
        else $error("pointer low byte");
    redirect_a: assert property (i_ext_req && i_ext_we && i_flash_redirect |=> o_flash_wr_req)
        else $error("flash write missing");
    no_redirect_a: assert property
        (!(i_ext_req && i_ext_we && i_flash_redirect) |=> !o_flash_wr_req)
        else $error("stray flash write");
    cover property (i_push);
    cover property (o_special_req);
    cover property (o_flash_wr_req);
endmodule

bind memory_space_decoder msd_checker #(.FLASH_LAST(FLASH_LAST)) u_chk (
    .i_clk(i_clk), .i_rst(i_rst), .i_code_addr(i_code_addr),
    .o_code_in_flash(o_code_in_flash), .o_code_is_lock(o_code_is_lock),
    .o_flash_addr(o_flash_addr), .i_data_req(i_data_req), .i_data_indirect(i_data_indirect),
    .i_data_bit(i_data_bit), .i_data_addr(i_data_addr), .o_special_req(o_special_req),
    .i_push(i_push), .i_pop(i_pop), .i_sp_we(i_sp_we), .o_stack_pointer(o_stack_pointer),
    .i_dph_we(i_dph_we), .i_dpl_we(i_dpl_we), .i_dp_wdata(i_dp_wdata),
    .o_data_pointer(o_data_pointer), .i_ext_req(i_ext_req), .i_ext_we(i_ext_we),
    .i_flash_redirect(i_flash_redirect), .o_flash_wr_req(o_flash_wr_req));

// ---- tb/memory_space_decoder_test.sv ----
// testbench: directed scenarios for the memory-space decoder
// assumes: checker bound separately, 4 kB flash variant
module test_memory_space_decoder;
    timeunit 1ns;
    timeprecision 100ps;
    // ****
    // stimulus and checks
    // ****
    localparam logic [15:0] FL = memdec_pkg::FLASH_LAST_4K;
    localparam logic [15:0] CA [4] = '{16'h0000, FL, FL + 16'h0001, 16'hFFFF};
    logic i_clk = 1'h0, i_rst = 1'h1, i_data_req = 1'h0, i_data_we = 1'h0;
    logic i_data_indirect = 1'h0, i_data_bit = 1'h0, i_ptr_sel = 1'h0, i_bit_wdata = 1'h0;
    logic i_push = 1'h0, i_pop = 1'h0, i_sp_we = 1'h0, i_dph_we = 1'h0, i_dpl_we = 1'h0;
    logic i_ext_req = 1'h0, i_ext_we = 1'h0, i_ext_use_dp = 1'h0, i_flash_redirect = 1'h0;
    logic [1:0] i_bank_sel = 2'h0;
    logic [15:0] i_code_addr = 16'h0000;
    logic [7:0] i_data_addr = 8'h00, i_data_wdata = 8'h00, i_push_data = 8'h00;
    logic [7:0] i_sp_wdata = 8'h00, i_dp_wdata = 8'h00, i_ext_wdata = 8'h00;
    logic o_code_in_flash, o_code_is_lock, o_bit_rdata, o_special_req, o_flash_wr_req;
    logic [15:0] o_flash_addr, o_data_pointer, o_flash_wr_addr, fwa;
    logic [7:0] o_data_rdata, o_special_addr, o_stack_pointer, o_ext_rdata, o_flash_wr_data;
    logic [7:0] rd, xr, fwd, sad;
    logic rb, spc, fw, m_in, m_lock;
    int n_fail = 0;
    int n_tests = 0;

    always #12.5 i_clk = ~i_clk;

    core_map_model #(.FLASH_LAST(FL)) u_model (.i_addr(i_code_addr), .o_in_flash(m_in),
        .o_is_lock(m_lock));
    memory_space_decoder #(.FLASH_LAST(FL)) u_dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_code_addr(i_code_addr),
        .o_code_in_flash(o_code_in_flash), .o_code_is_lock(o_code_is_lock),
        .o_flash_addr(o_flash_addr), .i_data_req(i_data_req), .i_data_we(i_data_we),
        .i_data_indirect(i_data_indirect), .i_data_bit(i_data_bit), .i_data_addr(i_data_addr),
        .i_ptr_sel(i_ptr_sel), .i_data_wdata(i_data_wdata), .i_bit_wdata(i_bit_wdata),
        .o_data_rdata(o_data_rdata), .o_bit_rdata(o_bit_rdata), .o_special_req(o_special_req),
        .o_special_addr(o_special_addr), .i_bank_sel(i_bank_sel), .i_push(i_push),
        .i_push_data(i_push_data), .i_pop(i_pop), .i_sp_we(i_sp_we), .i_sp_wdata(i_sp_wdata),
        .o_stack_pointer(o_stack_pointer), .i_dph_we(i_dph_we), .i_dpl_we(i_dpl_we),
        .i_dp_wdata(i_dp_wdata), .o_data_pointer(o_data_pointer), .i_ext_req(i_ext_req),
        .i_ext_we(i_ext_we), .i_ext_use_dp(i_ext_use_dp), .i_ext_wdata(i_ext_wdata),
        .i_flash_redirect(i_flash_redirect), .o_ext_rdata(o_ext_rdata),
        .o_flash_wr_req(o_flash_wr_req), .o_flash_wr_addr(o_flash_wr_addr),
        .o_flash_wr_data(o_flash_wr_data));

    task cyc;
        @(posedge i_clk);
        #1;
    endtask

    task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task close_out;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // one internal data access, read data captured while it stands
    task acc(input logic we, ind, bt, sel, input logic [7:0] a, d);
        {i_data_we, i_data_indirect, i_data_bit, i_ptr_sel} = {we, ind, bt, sel};
        i_data_addr = a;
        i_data_wdata = d;
        i_data_req = 1'h1;
        #1 {spc, sad} = {o_special_req, o_special_addr};
        cyc;
        {rd, rb} = {o_data_rdata, o_bit_rdata};
        i_data_req = 1'h0;
        cyc;
    endtask

    task ext(input logic we, dp, rdr, input logic [7:0] d);
        {i_ext_we, i_ext_use_dp, i_flash_redirect} = {we, dp, rdr};
        i_ext_wdata = d;
        i_ext_req = 1'h1;
        cyc;
        {xr, fw, fwa, fwd} = {o_ext_rdata, o_flash_wr_req, o_flash_wr_addr, o_flash_wr_data};
        i_ext_req = 1'h0;
        cyc;
    endtask

    // push, then sit out the pointer increment cycle
    task push(input logic [7:0] v);
        i_push_data = v;
        i_push = 1'h1;
        cyc;
        i_push = 1'h0;
        cyc;
        cyc;
    endtask

    task t_code;
        foreach (CA[k])
        begin
            i_code_addr = CA[k];
            #1;
            chk("in_flash", 16'(o_code_in_flash), 16'(m_in));
            chk("lock", 16'(o_code_is_lock), 16'(m_lock));
            chk("in_flash_map", 16'(o_code_in_flash), 16'(k < 2));
            chk("lock_map", 16'(o_code_is_lock), 16'(k == 1));
            chk("flash_addr", o_flash_addr, m_in ? CA[k] : 16'h0000);
            cyc;
        end
    endtask

    task t_stack;
        chk("sp_reset", 16'(o_stack_pointer), 16'h0007);
        push(8'hA5);
        chk("sp_push", 16'(o_stack_pointer), 16'h0008);
        acc(1'h0, 1'h0, 1'h0, 1'h0, 8'h08, 8'h00);
        chk("push_loc", 16'(rd), 16'h00A5);
        i_sp_wdata = 8'h7F;
        i_sp_we = 1'h1;
        cyc;
        i_sp_we = 1'h0;
        push(8'h3C);
        chk("sp_upper", 16'(o_stack_pointer), 16'h0080);
        i_pop = 1'h1;
        cyc;
        i_pop = 1'h0;
        chk("pop_data", 16'(o_data_rdata), 16'h003C);
        chk("sp_pop", 16'(o_stack_pointer), 16'h007F);
    endtask

    task t_bits;
        acc(1'h1, 1'h0, 1'h0, 1'h0, 8'h22, 8'h08);
        acc(1'h0, 1'h0, 1'h1, 1'h0, 8'h13, 8'h00);
        chk("bit_set", 16'(rb), 16'h0001);
        acc(1'h0, 1'h0, 1'h1, 1'h0, 8'h12, 8'h00);
        chk("bit_clr", 16'(rb), 16'h0000);
        i_bit_wdata = 1'h1;
        acc(1'h1, 1'h0, 1'h1, 1'h0, 8'h10, 8'h00);
        i_bit_wdata = 1'h0;
        acc(1'h0, 1'h0, 1'h0, 1'h0, 8'h22, 8'h00);
        chk("bit_write", 16'(rd), 16'h0009);
    endtask

    task t_bank;
        for (int b = 0; b < 4; b++)
        begin
            i_bank_sel = 2'(b);
            acc(1'h1, 1'h0, 1'h0, 1'h0, 8'(8 * b), 8'(8'h90 + b));
            acc(1'h1, 1'h1, 1'h0, 1'h0, 8'h00, 8'(8'hC0 + b));
        end
        for (int b = 0; b < 4; b++)
        begin
            i_bank_sel = 2'(b);
            acc(1'h1, 1'h0, 1'h0, 1'h0, 8'(8'h90 + b), 8'hFF);
            chk("special", 16'(spc), 16'h0001);
            chk("special_addr", 16'(sad), 16'(8'h90 + b));
            acc(1'h0, 1'h1, 1'h0, 1'h0, 8'h00, 8'h00);
            chk("upper_ind", 16'(rd), 16'(8'hC0 + b));
        end
    endtask

    task t_ext;
        i_dp_wdata = 8'h12;
        i_dph_we = 1'h1;
        cyc;
        i_dph_we = 1'h0;
        i_dp_wdata = 8'h34;
        i_dpl_we = 1'h1;
        cyc;
        i_dpl_we = 1'h0;
        chk("data_pointer", o_data_pointer, 16'h1234);
        i_bank_sel = 2'h0;
        acc(1'h1, 1'h0, 1'h0, 1'h0, 8'h01, 8'h34);
        ext(1'h1, 1'h1, 1'h0, 8'h5A);
        chk("no_flash", 16'(fw), 16'h0000);
        i_ptr_sel = 1'h1;
        ext(1'h0, 1'h0, 1'h0, 8'h00);
        chk("ext_r1", 16'(xr), 16'h005A);
        ext(1'h1, 1'h1, 1'h1, 8'hC3);
        chk("fl_req", 16'(fw), 16'h0001);
        chk("fl_addr", fwa, 16'h1234);
        chk("fl_data", 16'(fwd), 16'h00C3);
        ext(1'h0, 1'h1, 1'h0, 8'h00);
        chk("ext_kept", 16'(xr), 16'h005A);
    endtask

    initial
    begin
        repeat (20) @(posedge i_clk);
        #1 i_rst = 1'h0;
        t_stack;
        t_code;
        t_bits;
        t_bank;
        t_ext;
        close_out;
    end

    initial
    begin
        #200000;
        n_fail++;
        close_out;
    end
endmodule
